// *** inc/irq_pkg.sv ***
// Overview of operation
// (R1) source condition sets its pending flag
// (R2) flag sets even when source disabled
// (R3) enabled pending flag raises call request
// (R4) return resumes the interrupted program
// (R5) disabled pending flags are ignored
// (R6) each source has own enable bit
// (R7) global enable gates all sources
// (R8) some flags auto-clear on vectoring
// (R9) flag still set after return re-requests
// (R10) software may set pending flags
// (R11) trigger bit selects edge, polarity selects level
// (R12) pin chosen by config, sampled passively
// (R13) external flags at timer control bits 1,3
// (R14) edge flags clear on vectoring
// (R15) level flag follows active input
// (R16) level source holds until recognized
// (R17) per-source priority bit, resets low
// (R18) high preempts low, high never preempted
// (R19) higher level first, then fixed order
// (R20) pin skipped in crossbar, open drain
// (R21) sample and decode every clock
// (R22) equal level waits return plus instruction
// (R23) synchronise external pins before use
//
// Purpose: constants for the two-level interrupt handler
// Assumes: 17 sources in fixed order, vector 0x0003 + 8*index
// Notes: register offsets are indices on the plain register port
package irq_pkg;
  localparam int NSRC = 17;                      // number of sources
  localparam int SRC_EXT_A = 0;                  // external input a index
  localparam int SRC_EXT_B = 2;                  // external input b index
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;     // timer control reg
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;     // enable reg
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'hB8;       // priority reg
  localparam logic [7:0] ADDR_EXT_ENABLE1 = 8'hE6;    // extended enable 1
  localparam logic [7:0] ADDR_EXT_ENABLE2 = 8'hE7;    // extended enable 2
  localparam logic [7:0] ADDR_EXT_PRIO1 = 8'hF6;      // extended priority 1
  localparam logic [7:0] ADDR_EXT_PRIO2 = 8'hF7;      // extended priority 2
  localparam logic [7:0] ADDR_PIN_CONFIG = 8'hE4;     // pin config reg
  localparam logic [7:0] ADDR_PEND_SW = 8'hD0;        // soft pend, sources 8..15
  localparam logic [7:0] ADDR_PEND_SW2 = 8'hD1;       // soft pend, source 16
  localparam int BIT_GLOBAL = 7;                 // global enable bit
  localparam int BIT_A_TYPE = 0;                 // timer ctrl: a trigger type
  localparam int BIT_A_FLAG = 1;                 // timer ctrl: a pending
  localparam int BIT_B_TYPE = 2;                 // timer ctrl: b trigger type
  localparam int BIT_B_FLAG = 3;                 // timer ctrl: b pending
  localparam int BIT_A_POL = 3;                  // pin config: a polarity
  localparam int BIT_B_POL = 7;                  // pin config: b polarity
  localparam logic [7:0] RESET_BYTE = 8'h00;     // reset value of registers
  localparam logic [7:0] PIN_CFG_RESET = 8'h01;  // pin config reset value
  localparam logic [15:0] VEC_BASE = 16'h0003;   // first vector address
  localparam int VEC_SHIFT = 3;                  // 8 bytes between vectors
  localparam int LATENCY_NS = 48;                // 6 cycles at 8 ns
  localparam int CLK_NS = 8;                     // clock period
  localparam int LATENCY_CYC = LATENCY_NS / CLK_NS; // fastest response
  typedef enum logic [1:0] {lvl_none, lvl_low, lvl_high} lvl_t; // level in service
endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ns
// Purpose: two-stage synchroniser for the external pins
// Assumes: clk_en freezes the stages
// Notes: first stage feeds only the second
module pin_sync
  import irq_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta; // first stage, read by dout only
  // two flops per pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      dout <= '0;
    end else if (clk_en) begin
      meta <= din; // R23
      dout <= meta;
    end
  end
endmodule

// *** rtl/two_level_interrupt_handler.sv ***
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
// Purpose: pending flags, enables, two-level arbitration and call request
// Assumes: cpu pulses instr_done at each instruction end, call_ack when
//   it takes the vector, ret_done when the return instruction completes
// Notes: peripherals own their flags; their levels arrive on periph_pend
module two_level_interrupt_handler
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // port pins, up to 8 candidates per input
  input wire logic [7:0] port_pins,
  // peripheral pending levels, bits 0 and 2 unused (external)
  input wire logic [NSRC-1:0] periph_pend,
  output logic [NSRC-1:0] periph_clear, // auto-clear pulse on vectoring
  // cpu sequencer
  input wire logic instr_done,
  input wire logic call_ack,
  input wire logic ret_done,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [4:0] irq_src
);
  // software registers
  logic [7:0] timer_control_reg;   // type and flag bits live here
  logic [7:0] irq_enable_reg;
  logic [7:0] ext_irq_enable_reg1;
  logic [7:0] ext_irq_enable_reg2;
  logic [7:0] irq_priority_reg;
  logic [7:0] ext_irq_priority_reg1;
  logic [7:0] ext_irq_priority_reg2;
  logic [7:0] ext_irq_pin_config;
  logic [NSRC-1:0] soft_pend;      // software-set pends for peripheral sources
  // service state
  lvl_t in_service;                // highest level being serviced
  logic low_nested;                // a low routine lies under a high one
  logic hold_one;                  // must execute one instruction first
  logic [NSRC-1:0] ext_prev;       // previous active state for edges

  // pin selection and synchronisation
  logic [1:0] pin_raw;
  logic [1:0] pin_s;
  assign pin_raw[0] = port_pins[ext_irq_pin_config[2:0]]; // R12
  assign pin_raw[1] = port_pins[ext_irq_pin_config[6:4]]; // R12
  pin_sync #(.W(2)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .din(pin_raw),
    .dout(pin_s)
  );

  // active level per selected polarity
  wire ext_a_polarity = ext_irq_pin_config[BIT_A_POL];
  wire ext_b_polarity = ext_irq_pin_config[BIT_B_POL];
  wire ext_a_trigger_type = timer_control_reg[BIT_A_TYPE];
  wire ext_b_trigger_type = timer_control_reg[BIT_B_TYPE];
  wire act_a = ext_a_polarity ? pin_s[0] : ~pin_s[0]; // R11
  wire act_b = ext_b_polarity ? pin_s[1] : ~pin_s[1]; // R11
  wire edge_a = act_a & ~ext_prev[SRC_EXT_A];
  wire edge_b = act_b & ~ext_prev[SRC_EXT_B];

  // register write decode
  wire wr_timer_control_reg = reg_wr & (reg_addr == ADDR_TIMER_CTRL);
  wire wr_ie = reg_wr & (reg_addr == ADDR_IRQ_ENABLE);
  wire wr_eie1 = reg_wr & (reg_addr == ADDR_EXT_ENABLE1);
  wire wr_ext_irq_enable_reg2 = reg_wr & (reg_addr == ADDR_EXT_ENABLE2);
  wire wr_ip = reg_wr & (reg_addr == ADDR_IRQ_PRIO);
  wire wr_eip1 = reg_wr & (reg_addr == ADDR_EXT_PRIO1);
  wire wr_ext_irq_priority_reg2 = reg_wr & (reg_addr == ADDR_EXT_PRIO2);
  wire wr_pcfg = reg_wr & (reg_addr == ADDR_PIN_CONFIG);
  wire wr_soft = reg_wr & (reg_addr == ADDR_PEND_SW);
  wire wr_soft2 = reg_wr & (reg_addr == ADDR_PEND_SW2);

  // gathered enables and priorities, in fixed source order
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_hi;
  // 7 + 8 + 2 bits: sources 15 and 16 sit in bits 0 and 1 of the second ext reg
  assign src_en = {ext_irq_enable_reg2[1:0], ext_irq_enable_reg1,
                   irq_enable_reg[6:0]}; // R6
  assign src_hi = {ext_irq_priority_reg2[1:0], ext_irq_priority_reg1,
                   irq_priority_reg[6:0]}; // R17

  // pending vector: external flags from timer control, others from peripherals
  logic [NSRC-1:0] pend;
  always_comb begin
    pend = periph_pend | soft_pend; // R1 R2 R10
    pend[SRC_EXT_A] = timer_control_reg[BIT_A_FLAG]; // R13
    pend[SRC_EXT_B] = timer_control_reg[BIT_B_FLAG]; // R13
  end

  // gate: disabled pends are simply ignored
  wire global_irq_enable = irq_enable_reg[BIT_GLOBAL];
  wire [NSRC-1:0] live = pend & src_en & {NSRC{global_irq_enable}}; // R5 R7
  wire [NSRC-1:0] live_hi = live & src_hi;
  wire [NSRC-1:0] live_lo = live & ~src_hi;

  // lowest index wins among equal levels
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // arbitration, evaluated every cycle
  wire any_hi = |live_hi;
  wire any_lo = |live_lo;
  wire [4:0] pick = any_hi ? first_set(live_hi) : first_set(live_lo); // R19 R21
  // high may enter unless high is already in service; low only when idle
  wire may_hi = any_hi & (in_service != lvl_high); // R18
  wire may_lo = any_lo & (in_service == lvl_none); // R18 R22
  wire want = (may_hi | may_lo) & ~hold_one; // R22 R9

  // request is combinational so the cpu sees it in the detect cycle
  assign irq_req = want; // R3
  assign irq_src = pick;
  assign irq_vector = VEC_BASE + {6'h00, pick, 5'h00} / 16'h0004; // R3
  wire take = call_ack & want;
  wire take_a = take & (pick == 5'(SRC_EXT_A));
  wire take_b = take & (pick == 5'(SRC_EXT_B));

  // auto-clear pulse to peripherals whose flags clear on vectoring
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_clear <= '0;
    end else if (clk_en) begin
      periph_clear <= '0;
      if (take) begin
        periph_clear[pick] <= 1'b1; // R8
      end
    end
  end

  // timer control: external flags, edge set wins over clears
  logic [7:0] next_timer_control_reg;
  always_comb begin
    next_timer_control_reg = wr_timer_control_reg ? reg_wdata : timer_control_reg; // R10
    if (!ext_a_trigger_type) begin
      next_timer_control_reg[BIT_A_FLAG] = act_a; // R15
    end else begin
      if (take_a) next_timer_control_reg[BIT_A_FLAG] = 1'b0; // R14 R8
      if (edge_a) next_timer_control_reg[BIT_A_FLAG] = 1'b1; // R1
    end
    if (!ext_b_trigger_type) begin
      next_timer_control_reg[BIT_B_FLAG] = act_b; // R15
    end else begin
      if (take_b) next_timer_control_reg[BIT_B_FLAG] = 1'b0; // R14 R8
      if (edge_b) next_timer_control_reg[BIT_B_FLAG] = 1'b1; // R1
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_control_reg <= RESET_BYTE;
      irq_enable_reg <= RESET_BYTE;
      ext_irq_enable_reg1 <= RESET_BYTE;
      ext_irq_enable_reg2 <= RESET_BYTE;
      irq_priority_reg <= RESET_BYTE; // R17
      ext_irq_priority_reg1 <= RESET_BYTE; // R17
      ext_irq_priority_reg2 <= RESET_BYTE; // R17
      ext_irq_pin_config <= PIN_CFG_RESET;
    end else if (clk_en) begin
      timer_control_reg <= next_timer_control_reg;
      if (wr_ie) irq_enable_reg <= reg_wdata;
      if (wr_eie1) ext_irq_enable_reg1 <= reg_wdata;
      if (wr_ext_irq_enable_reg2) ext_irq_enable_reg2 <= reg_wdata;
      if (wr_ip) irq_priority_reg <= reg_wdata;
      if (wr_eip1) ext_irq_priority_reg1 <= reg_wdata;
      if (wr_ext_irq_priority_reg2) ext_irq_priority_reg2 <= reg_wdata;
      if (wr_pcfg) ext_irq_pin_config <= reg_wdata;
    end
  end

  // software pends for peripheral sources; cleared on vectoring to them
  logic [NSRC-1:0] next_soft;
  always_comb begin
    next_soft = soft_pend;
    if (wr_soft) next_soft[15:8] = reg_wdata; // R10
    if (wr_soft2) next_soft[16] = reg_wdata[0]; // R10
    if (take) next_soft[pick] = 1'b0;
    next_soft[SRC_EXT_A] = 1'b0; // external sources use timer control
    next_soft[SRC_EXT_B] = 1'b0;
  end

  // edge history and soft pends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_pend <= '0;
      ext_prev <= '0;
    end else if (clk_en) begin
      soft_pend <= next_soft;
      ext_prev[SRC_EXT_A] <= act_a;
      ext_prev[SRC_EXT_B] <= act_b;
    end
  end

  // service level tracking and one-instruction hold after return
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_service <= lvl_none;
      low_nested <= 1'b0;
      hold_one <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        if (in_service == lvl_low) low_nested <= 1'b1; // R18
        in_service <= any_hi ? lvl_high : lvl_low;
      end else if (ret_done) begin
        hold_one <= 1'b1; // R9 R22
        if (in_service == lvl_high && low_nested) begin
          in_service <= lvl_low; // R4
          low_nested <= 1'b0;
        end else begin
          in_service <= lvl_none; // R4
        end
      end else if (instr_done) begin
        hold_one <= 1'b0; // R9
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      ADDR_TIMER_CTRL: rd_mux = timer_control_reg;
      ADDR_IRQ_ENABLE: rd_mux = irq_enable_reg;
      ADDR_EXT_ENABLE1: rd_mux = ext_irq_enable_reg1;
      ADDR_EXT_ENABLE2: rd_mux = ext_irq_enable_reg2;
      ADDR_IRQ_PRIO: rd_mux = irq_priority_reg;
      ADDR_EXT_PRIO1: rd_mux = ext_irq_priority_reg1;
      ADDR_EXT_PRIO2: rd_mux = ext_irq_priority_reg2;
      ADDR_PIN_CONFIG: rd_mux = ext_irq_pin_config;
      ADDR_PEND_SW: rd_mux = pend[15:8];
      ADDR_PEND_SW2: rd_mux = {7'h00, pend[16]};
      default: rd_mux = 8'h00;
    endcase
  end

  // read register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end
endmodule

// *** tb/irq_chk.sv ***
`timescale 1ns/1ns
// Purpose: port-level checks of the interrupt handler
// Assumes: enable reg shadowed from taken writes
// Notes: bound below to every handler instance
module irq_chk
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NSRC-1:0] periph_clear,
  input wire logic call_ack,
  input wire logic ret_done,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [4:0] irq_src
);
  logic [7:0] ie; // shadow of the enable reg
  // shadow follows taken writes only, so a frozen clock leaves it alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ie <= 8'h00;
    else if (clk_en && reg_wr && reg_addr == ADDR_IRQ_ENABLE) ie <= reg_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_enable_read: assert property (
    clk_en && reg_rd && reg_addr == ADDR_IRQ_ENABLE |=> reg_rdata == $past(ie))
    else $error("enable reg read wrong");
  a_global_gate: assert property (!ie[BIT_GLOBAL] |-> !irq_req)
    else $error("request with global enable off");
  a_src_enable: assert property (irq_req && irq_src < 5'h07 |-> ie[irq_src])
    else $error("request from disabled source");
  a_vector_map: assert property (
    irq_req |-> irq_vector == VEC_BASE + (16'(irq_src) << VEC_SHIFT))
    else $error("vector does not match source");
  a_clear_cause: assert property (|periph_clear |-> $past(call_ack && irq_req))
    else $error("clear pulse without vectoring");
  a_clear_src: assert property (
    clk_en && call_ack && irq_req |=> periph_clear == (17'h00001 << $past(irq_src)))
    else $error("clear pulse on wrong source");
  a_ret_quiet: assert property (ret_done |=> !irq_req)
    else $error("request right after return");
  a_clear_single: assert property ($onehot0(periph_clear))
    else $error("several sources vectored at once");
endmodule

bind two_level_interrupt_handler irq_chk chk (.clk(clk), .nrst(nrst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .periph_clear(periph_clear), .call_ack(call_ack),
  .ret_done(ret_done), .irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src));

// *** tb/cpu_model.sv ***
`timescale 1ns/1ns
// Purpose: cpu sequencer seen from the interrupt handler
// Assumes: one instruction every GAP cycles, SVC instructions per routine
// Notes: nesting is a plain depth count, return resumes the outer routine
module cpu_model #(
  parameter int GAP = 2,
  parameter int SVC = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic irq_req,
  output logic instr_done,
  output logic call_ack,
  output logic ret_done
);
  int tick, svc, depth; // cycle in instruction, instructions done in routine, nesting
  // a call is taken only at an instruction end, never in mid-instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {instr_done, call_ack, ret_done} <= 3'h0;
      tick <= 0;
      svc <= 0;
      depth <= 0;
    end else begin
      instr_done <= 1'b0;
      call_ack <= 1'b0;
      ret_done <= 1'b0;
      if (instr_done && irq_req) begin
        call_ack <= 1'b1;
        depth <= depth + 1;
        svc <= 0;
        tick <= 0;
      end else if (tick == GAP - 1) begin
        tick <= 0;
        if (depth != 0 && svc == SVC) begin
          ret_done <= 1'b1;
          depth <= depth - 1;
          svc <= 0;
        end else begin
          instr_done <= 1'b1;
          svc <= svc + 1;
        end
      end else tick <= tick + 1;
    end
  end
endmodule

// *** tb/two_level_interrupt_handler_tb.sv ***
`timescale 1ns/1ns
// Purpose: register and call sequences against the interrupt handler
// Assumes: peripherals drop their flag on the clear pulse
// Notes: clk_en tied high, freezing is not exercised
module two_level_interrupt_handler_tb;
  import irq_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, instr_done, call_ack, ret_done, irq_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_pins;
  logic [NSRC-1:0] periph_pend, periph_clear, pend_set;
  logic [15:0] irq_vector;
  logic [4:0] irq_src;
  int n_mismatch, tests_run;
  two_level_interrupt_handler dut (.clk(clk), .nrst(nrst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_pins(port_pins), .periph_pend(periph_pend),
    .periph_clear(periph_clear), .instr_done(instr_done), .call_ack(call_ack),
    .ret_done(ret_done), .irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src));
  cpu_model #(.GAP(2), .SVC(4)) cpu (.clk(clk), .nrst(nrst), .irq_req(irq_req),
    .instr_done(instr_done), .call_ack(call_ack), .ret_done(ret_done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // peripheral flags: raised by the bench, dropped on the clear pulse
  always @(posedge clk or negedge nrst) begin
    if (!nrst) periph_pend <= '0;
    else periph_pend <= (periph_pend | pend_set) & ~periph_clear;
  end
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, 16'(exp), 16'(reg_rdata));
  endtask
  task automatic pend(logic [NSRC-1:0] m);
    @(posedge clk);
    pend_set <= m;
    @(posedge clk);
    pend_set <= '0;
  endtask
  // bounded wait for a request, then source and vector are compared
  task automatic wait_req(logic [4:0] s);
    int i;
    #1;
    for (i = 0; i < 200 && irq_req !== 1'b1; i++) @(posedge clk) #1;
    if (i == 200) begin
      n_mismatch++;
      $display("unexpected request: expected %0d, seen none", s);
      final_report();
    end
    chk("source", 16'(s), 16'(irq_src));
    chk("vector", VEC_BASE + (16'(s) << VEC_SHIFT), irq_vector);
  endtask
  initial begin
    {nrst, reg_wr, reg_rd} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    port_pins = 8'hFF;
    pend_set = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_IRQ_ENABLE, 8'h00, "enable reset");
    rd(ADDR_IRQ_PRIO, 8'h00, "priority reset");
    rd(ADDR_EXT_PRIO2, 8'h00, "ext priority reset");
    rd(ADDR_PIN_CONFIG, PIN_CFG_RESET, "pin config reset");
    rd(8'h55, 8'h00, "unmapped read");
    // edge, active low on pin 1, global enable still off
    wr(ADDR_TIMER_CTRL, 8'h01);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    port_pins <= 8'hFD;
    repeat (6) @(posedge clk);
    rd(ADDR_TIMER_CTRL, 8'h03, "edge flag");
    chk("masked request", 16'h0000, 16'(irq_req));
    port_pins <= 8'hFF;
    wr(ADDR_IRQ_ENABLE, 8'h81);
    wait_req(SRC_EXT_A);
    repeat (12) @(posedge clk);
    rd(ADDR_TIMER_CTRL, 8'h01, "edge flag cleared");
    // level, active high on pin 3; pin 1 must be ignored
    wr(ADDR_IRQ_ENABLE, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h00);
    wr(ADDR_PIN_CONFIG, 8'h0B);
    port_pins <= 8'h09;
    repeat (6) @(posedge clk);
    rd(ADDR_TIMER_CTRL, 8'h02, "level flag active");
    port_pins <= 8'h03;
    repeat (6) @(posedge clk);
    rd(ADDR_TIMER_CTRL, 8'h00, "level flag idle");
    // software-set flag, blocked by its own enable first
    wr(ADDR_IRQ_ENABLE, 8'h80);
    wr(ADDR_PEND_SW, 8'h01);
    repeat (4) @(posedge clk);
    chk("disabled source", 16'h0000, 16'(irq_req));
    wr(ADDR_EXT_ENABLE1, 8'h02);
    wait_req(5'h08);
    repeat (40) @(posedge clk);
    // two sources raised together, both priority settings
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_IRQ_ENABLE, 8'h0A);
      wr(ADDR_IRQ_PRIO, k ? 8'h08 : 8'h00);
      pend(17'h0000A);
      wr(ADDR_IRQ_ENABLE, 8'h8A);
      wait_req(k ? 5'h03 : 5'h01);
      repeat (60) @(posedge clk);
    end
    // high level preempts a low routine in service
    pend(17'h00002);
    wait_req(5'h01);
    repeat (4) @(posedge clk);
    pend(17'h00008);
    wait_req(5'h03);
    repeat (60) @(posedge clk);
    final_report();
  end
endmodule
